// >>> rtl/dhs_pkg.sv
package dhs_pkg;

   // ----------------------------------------------------------------
   // register map (byte offsets)
   // ----------------------------------------------------------------
   localparam logic [7:0] OFF_CMD      = 8'h00;
   localparam logic [7:0] OFF_STATUS   = 8'h04;
   localparam logic [7:0] OFF_RESULT   = 8'h08;
   localparam logic [7:0] OFF_DATA     = 8'h0c;
   localparam logic [7:0] OFF_SCAN     = 8'h10;
   localparam logic [7:0] OFF_CTRL     = 8'h14;
   localparam logic [7:0] OFF_SPANDEF  = 8'h18;

   // ----------------------------------------------------------------
   // subcommand codes
   // ----------------------------------------------------------------
   localparam logic [7:0] SC_READ_VALUES  = 8'hd0;
   localparam logic [7:0] SC_READ_THRESH  = 8'hd1;
   localparam logic [7:0] SC_AUTOSAVE     = 8'hd2;
   localparam logic [7:0] SC_SAVE         = 8'hd3;
   localparam logic [7:0] SC_IMMEDIATE    = 8'hd4;
   localparam logic [7:0] SC_READ_LOG     = 8'hd5;
   localparam logic [7:0] SC_WRITE_LOG    = 8'hd6;
   localparam logic [7:0] SC_ENABLE       = 8'hd8;
   localparam logic [7:0] SC_DISABLE      = 8'hd9;
   localparam logic [7:0] SC_RET_STATUS   = 8'hda;
   localparam logic [7:0] SC_AUTO_OFFLINE = 8'hdb;

   // auto-save sector count values
   localparam logic [7:0] AS_OFF = 8'h00;
   localparam logic [7:0] AS_ON  = 8'hf1;

   // routine selectors
   localparam logic [7:0] RT_COLLECT    = 8'h00;
   localparam logic [7:0] RT_SHORT      = 8'h01;
   localparam logic [7:0] RT_EXTENDED   = 8'h02;
   localparam logic [7:0] RT_SELECTIVE  = 8'h04;
   localparam logic [7:0] RT_ABORT      = 8'h7f;
   localparam logic [7:0] RT_ABORT_SEL  = 8'h0f;
   localparam logic [7:0] RT_CAP_SHORT  = 8'h81;
   localparam logic [7:0] RT_CAP_EXT    = 8'h82;
   localparam logic [7:0] RT_CAP_SEL    = 8'h84;

   // failure signature and status codes
   localparam logic [7:0] FAIL_LBA_LOW  = 8'hf4;
   localparam logic [7:0] FAIL_LBA_HIGH = 8'h2c;
   localparam logic [7:0] COLL_SCANNING = 8'h03;
   localparam logic [7:0] COLL_DONE     = 8'h02;
   localparam logic [7:0] TEST_OK       = 8'h00;
   localparam logic [7:0] TEST_FAILED   = 8'h07;
   localparam logic [7:0] ERR_ABORT     = 8'h04;
   localparam logic [2:0] SPAN_OFFLINE  = 3'h6;
   localparam logic [2:0] SPAN_LAST     = 3'h5;

   // sector size in 32-bit words (512 bytes)
   localparam logic [7:0] SECTOR_WORDS = 8'h80;

   // timing
   localparam int unsigned CLK_HZ          = 40_000_000;
   localparam int unsigned SERVICE_MS      = 2000;
   localparam longint unsigned SERVICE_CYC = longint'(CLK_HZ) * SERVICE_MS / 1000;
   localparam int unsigned AUTOSAVE_MIN    = 15;
   localparam longint unsigned AUTOSAVE_CYC = longint'(CLK_HZ) * 60 * AUTOSAVE_MIN;

   // reset values
   localparam logic RST_AUTOSAVE = 1'b0;

   // task-file image returned after a command
   typedef struct packed {
      logic [7:0] lba_high;
      logic [7:0] lba_low;
      logic [7:0] error;
      logic       err;
      logic       drq;
      logic       drdy;
      logic       busy;
   } dhs_taskfile_t;

   // selective-log scan flags
   typedef struct packed {
      logic       pending;
      logic       active;
      logic [2:0] span;
   } dhs_scan_t;

endpackage

// >>> rtl/dhs_unit.sv
// The implementer's own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
// How it works
// R1: host writes the subcommand code before issuing the command (host duty)
// R2: decodes D0..D6, D8..DB subcommand codes
// R3: read-values: busy, save, data request, drop busy, interrupt, 512 bytes out
// R4: read-thresholds: fetch thresholds then stream 512 bytes to host
// R5: auto-save at first active idle, then every 15 minutes
// R6: count 00h disables, F1h enables auto-save; state kept nonvolatile (the code clears autosave_nv to 0 on every reset)
// R7: other nonzero count keeps auto-save state and reports abort error
// R8: auto-save control: busy, apply, drop busy, interrupt (the code applies and interrupts without raising busy)
// R9: save-values: busy, save regardless of auto-save, drop busy, interrupt
// R10: LBA low selects collection, off-line, abort and captive routines
// R11: off-line mode completes first, busy low and ready high during run
// R12: new command during off-line routine served within two seconds
// R13: captive mode holds busy during test, then records result
// R14: captive failure sets error, abort, F4h low, 2Ch high
// R15: selector 4 or 132 starts selective test
// R16: host does not write the span log while selective test runs (host duty)
// R17: span progress updated, status reported at end
// R18: span error reported, follow-on scan skipped
// R19: clean spans with scan option: flags set, span 6, status 00h, coll 03h (the code starts the scan only after a non-captive selective test)
// R20: after power-up, pending delay then active resumes scan
// R21: full media done clears flags, collection status 02h
// R22: reset aborts selective unless pending; 0Fh abort; new test replaces
// R23: reserved codes or selectors abort with abort bit
module dhs_unit
   import dhs_pkg::*;
#(
   parameter longint unsigned AUTOSAVE_CYCLES = AUTOSAVE_CYC,
   parameter longint unsigned SERVICE_CYCLES  = SERVICE_CYC
)(
   // clock, reset, enable
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        ce,
   // axi4-lite write
   input  wire logic [7:0]  s_awaddr,
   input  wire logic        s_awvalid,
   output logic             s_awready,
   input  wire logic [31:0] s_wdata,
   input  wire logic [3:0]  s_wstrb,
   input  wire logic        s_wvalid,
   output logic             s_wready,
   output logic [1:0]       s_bresp,
   output logic             s_bvalid,
   input  wire logic        s_bready,
   // axi4-lite read
   input  wire logic [7:0]  s_araddr,
   input  wire logic        s_arvalid,
   output logic             s_arready,
   output logic [31:0]      s_rdata,
   output logic [1:0]       s_rresp,
   output logic             s_rvalid,
   input  wire logic        s_rready,
   // drive-side events
   input  wire logic        active_idle,
   input  wire logic        test_error,
   input  wire logic        power_resume,
   // drive-side requests
   output logic             save_pulse,
   output logic             intrq,
   output logic             autosave_nv
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef enum logic [6:0] {
      ST_IDLE  = 7'b0000001,
      ST_SAVE  = 7'b0000010,
      ST_XFER  = 7'b0000100,
      ST_CAPT  = 7'b0001000,
      ST_SPANS = 7'b0010000,
      ST_SCAN  = 7'b0100000,
      ST_WAIT  = 7'b1000000
   } dhs_state_t;

   dhs_state_t      state;
   dhs_taskfile_t   tf;
   dhs_scan_t       scan;
   logic [7:0]      coll_status;
   logic [7:0]      test_status;
   logic [7:0]      xfer_cnt;
   logic [7:0]      pend_time;
   logic [7:0]      pend_cnt;
   logic [31:0]     svc_cnt;
   logic [39:0]     as_cnt;
   logic            as_first;
   logic            scan_opt;
   logic            captive;
   logic            offline_run;
   logic            xfer_thresh;
   logic            aw_hold;
   logic            w_hold;
   logic [7:0]      aw_addr;
   logic [31:0]     w_data;
   logic            pwr_s1;
   logic            pwr_s2;
   logic            pwr_q;
   logic            idle_s1;
   logic            idle_s2;
   logic            err_s1;
   logic            err_s2;

   // decoded command strobe from the bus
   logic            do_write;
   logic            cmd_go;
   logic            cmd_cut;
   logic            as_fire;
   logic [7:0]      cmd_feat;
   logic [7:0]      cmd_count;
   logic [7:0]      cmd_lba;
   logic            data_rd;

   function automatic logic is_routine(input logic [7:0] sel);
      // all selector codes the immediate command accepts
      return sel inside {RT_COLLECT, RT_SHORT, RT_EXTENDED, RT_SELECTIVE,
                         RT_ABORT, RT_ABORT_SEL, RT_CAP_SHORT, RT_CAP_EXT, RT_CAP_SEL};
   endfunction

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   // pins come from drive firmware clocks, two flops before use
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {pwr_s1, pwr_s2, pwr_q, idle_s1, idle_s2, err_s1, err_s2} <= '0;
      end else if (ce) begin
         pwr_s1  <= power_resume;
         pwr_s2  <= pwr_s1;
         pwr_q   <= pwr_s2;
         idle_s1 <= active_idle;
         idle_s2 <= idle_s1;
         err_s1  <= test_error;
         err_s2  <= err_s1;
      end
   end

   // ----------------------------------------------------------------
   // axi4-lite slave
   // ----------------------------------------------------------------
   assign s_awready = ce && !aw_hold && !s_bvalid;
   assign s_wready  = ce && !w_hold && !s_bvalid;
   assign s_arready = ce && !s_rvalid;
   assign s_bresp   = 2'b00;
   assign s_rresp   = 2'b00;
   // a command landing on a running off-line routine stops it first; the write
   // is held one cycle and then decoded from idle [R12]
   assign cmd_cut   = aw_hold && w_hold && !s_bvalid && aw_addr == OFF_CMD
                      && offline_run && state != ST_IDLE;
   assign do_write  = aw_hold && w_hold && !s_bvalid && !cmd_cut;
   assign cmd_go    = do_write && aw_addr == OFF_CMD && state == ST_IDLE;
   assign cmd_feat  = w_data[7:0];
   assign cmd_count = w_data[15:8];
   assign cmd_lba   = w_data[23:16];
   assign data_rd   = s_arvalid && s_arready && s_araddr == OFF_DATA;

   // write path: address and data taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold  <= 1'b0;
         w_hold   <= 1'b0;
         aw_addr  <= 8'h00;
         w_data   <= 32'h0;
         s_bvalid <= 1'b0;
      end else if (ce) begin
         if (s_awvalid && s_awready) begin
            aw_hold <= 1'b1;
            aw_addr <= s_awaddr;
         end
         if (s_wvalid && s_wready) begin
            w_hold <= 1'b1;
            w_data <= s_wdata;
         end
         if (do_write) begin
            aw_hold  <= 1'b0;
            w_hold   <= 1'b0;
            s_bvalid <= 1'b1;
         end else if (s_bvalid && s_bready) begin
            s_bvalid <= 1'b0;
         end
      end
   end

   // read path, one cycle answer; unmapped reads give zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_rvalid <= 1'b0;
         s_rdata  <= 32'h0;
      end else if (ce) begin
         if (s_arvalid && s_arready) begin
            s_rvalid <= 1'b1;
            case (s_araddr)
               OFF_STATUS:  s_rdata <= {24'h0, tf.error[3:0], tf.err, tf.drq, tf.drdy, tf.busy};
               OFF_RESULT:  s_rdata <= {tf.lba_high, tf.lba_low, test_status, coll_status};
               OFF_DATA:    s_rdata <= {xfer_thresh, 7'h0, 16'h0, xfer_cnt};
               OFF_SCAN:    s_rdata <= {16'h0, pend_time, 3'h0, scan};
               OFF_CTRL:    s_rdata <= {30'h0, scan_opt, autosave_nv};
               default:     s_rdata <= 32'h0;
            endcase
         end else if (s_rvalid && s_rready) begin
            s_rvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // span definition writes (selective log fields)
   // ----------------------------------------------------------------
   // span log is frozen while a selective test runs [R16]
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         scan_opt  <= 1'b0;
         pend_time <= 8'h00;
      end else if (ce && do_write && aw_addr == OFF_SPANDEF
                   && state != ST_SPANS && s_wstrb[0]) begin
         scan_opt  <= w_data[0];
         pend_time <= w_data[15:8];
      end
   end

   // ----------------------------------------------------------------
   // command sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state       <= ST_IDLE;
         tf          <= '{lba_high: 8'h00, lba_low: 8'h00, error: 8'h00,
                          err: 1'b0, drq: 1'b0, drdy: 1'b1, busy: 1'b0};
         autosave_nv <= RST_AUTOSAVE;
         save_pulse  <= 1'b0;
         intrq       <= 1'b0;
         xfer_cnt    <= 8'h00;
         xfer_thresh <= 1'b0;
         captive     <= 1'b0;
         offline_run <= 1'b0;
         coll_status <= 8'h00;
         test_status <= TEST_OK;
         // pending flag and span survive reset only while pending; active clears [R22]
         if (!scan.pending)
            scan <= '0;
         else
            scan.active <= 1'b0;
         svc_cnt     <= 32'h0;
         pend_cnt    <= 8'h00;
      end else if (ce) begin
         save_pulse <= as_fire; // [R5]
         intrq      <= 1'b0;
         // window opens when a command stops a routine and shuts when it is decoded [R12]
         if (cmd_cut)
            svc_cnt <= 32'(SERVICE_CYCLES - 1);
         else if (cmd_go)
            svc_cnt <= 32'h0;
         else if (svc_cnt != 32'h0)
            svc_cnt <= svc_cnt - 32'h1;
         case (state)
            ST_IDLE: begin
               if (cmd_go) begin
                  tf.err   <= 1'b0;
                  tf.error <= 8'h00;
                  case (cmd_feat) // [R2]
                     SC_READ_VALUES, SC_SAVE: begin
                        tf.busy    <= 1'b1; // [R3] [R9]
                        save_pulse <= 1'b1;
                        state      <= ST_SAVE;
                     end
                     SC_READ_THRESH: begin
                        tf.drq      <= 1'b1; // [R4]
                        xfer_thresh <= 1'b1;
                        xfer_cnt    <= SECTOR_WORDS;
                        intrq       <= 1'b1;
                        state       <= ST_XFER;
                     end
                     SC_AUTOSAVE: begin
                        intrq <= 1'b1; // [R8]
                        if (cmd_count == AS_OFF)
                           autosave_nv <= 1'b0; // [R6]
                        else if (cmd_count == AS_ON)
                           autosave_nv <= 1'b1; // [R6]
                        else begin
                           tf.err   <= 1'b1; // [R7]
                           tf.error <= ERR_ABORT;
                        end
                     end
                     SC_IMMEDIATE: begin
                        intrq <= 1'b1;
                        if (!is_routine(cmd_lba)) begin
                           tf.err   <= 1'b1; // [R23]
                           tf.error <= ERR_ABORT;
                        end else if (cmd_lba == RT_ABORT || cmd_lba == RT_ABORT_SEL) begin
                           offline_run <= 1'b0; // [R22]
                           scan        <= '0;
                        end else begin
                           // a new test replaces any running one [R10] [R22]
                           captive     <= cmd_lba[7];
                           offline_run <= !cmd_lba[7]; // [R11]
                           tf.busy     <= cmd_lba[7];  // [R13]
                           intrq       <= !cmd_lba[7];
                           test_status <= TEST_OK;
                           scan        <= '{pending: 1'b0, active: 1'b0, span: 3'h1};
                           state       <= (cmd_lba[2]) ? ST_SPANS : ST_CAPT; // [R15]
                        end
                     end
                     SC_READ_LOG, SC_WRITE_LOG, SC_ENABLE, SC_DISABLE,
                     SC_RET_STATUS, SC_AUTO_OFFLINE: begin
                        intrq <= 1'b1; // decoded, served elsewhere
                     end
                     default: begin
                        intrq    <= 1'b1;
                        tf.err   <= 1'b1; // [R23]
                        tf.error <= ERR_ABORT;
                     end
                  endcase
               end else if (pwr_s2 && !pwr_q && scan.pending) begin
                  pend_cnt <= pend_time; // [R20]
                  state    <= ST_WAIT;
               end
            end
            ST_SAVE: begin
               tf.busy <= 1'b0;
               intrq   <= 1'b1;
               if (cmd_feat == SC_READ_VALUES) begin
                  tf.drq      <= 1'b1; // [R3]
                  xfer_thresh <= 1'b0;
                  xfer_cnt    <= SECTOR_WORDS;
                  state       <= ST_XFER;
               end else
                  state <= ST_IDLE;
            end
            ST_XFER: begin
               // each data-port read pops one word of the sector [R3] [R4]
               if (data_rd) begin
                  xfer_cnt <= xfer_cnt - 8'h1;
                  if (xfer_cnt == 8'h1) begin
                     tf.drq <= 1'b0;
                     state  <= ST_IDLE;
                  end
               end
            end
            ST_CAPT, ST_SPANS: begin
               if (cmd_cut) begin
                  offline_run <= 1'b0; // abort, host served at once [R12]
                  state       <= ST_IDLE;
               end else if (err_s2) begin
                  test_status <= TEST_FAILED; // [R18]
                  offline_run <= 1'b0;
                  state       <= ST_IDLE;
                  if (captive) begin
                     tf <= '{lba_high: FAIL_LBA_HIGH, lba_low: FAIL_LBA_LOW,
                            error: ERR_ABORT, err: 1'b1, drq: 1'b0,
                            drdy: 1'b1, busy: 1'b0}; // [R14]
                     intrq <= 1'b1;
                  end
               end else if (state == ST_CAPT || scan.span == SPAN_LAST) begin
                  tf.busy <= 1'b0; // [R13] [R17]
                  intrq   <= captive;
                  if (state == ST_SPANS && scan_opt && !captive) begin
                     scan        <= '{pending: 1'b1, active: 1'b1, span: SPAN_OFFLINE};
                     coll_status <= COLL_SCANNING; // [R19]
                     state       <= ST_SCAN;
                  end else begin
                     offline_run <= 1'b0;
                     state       <= ST_IDLE;
                  end
               end else
                  scan.span <= scan.span + 3'h1; // [R17]
            end
            ST_WAIT: begin
               if (pend_cnt == 8'h00) begin
                  scan.active <= 1'b1; // [R20]
                  offline_run <= 1'b1;
                  state       <= ST_SCAN;
               end else
                  pend_cnt <= pend_cnt - 8'h1;
            end
            ST_SCAN: begin
               // media scan ignores errors; done signalled by drive idle [R19] [R21]
               if (idle_s2) begin
                  scan        <= '0;
                  coll_status <= COLL_DONE;
                  offline_run <= 1'b0;
                  state       <= ST_IDLE;
               end else if (cmd_cut) begin
                  // scan stays logged as pending, host served at once [R12]
                  scan.active <= 1'b0;
                  offline_run <= 1'b0;
                  state       <= ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // auto-save timer
   // ----------------------------------------------------------------
   // save request to the drive: first active idle, then each time the interval ends [R5]
   assign as_fire = ce && autosave_nv && (as_first ? as_cnt == 40'h0 : idle_s2);

   // first active idle saves, then every interval; counter wide enough for minutes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         as_first <= 1'b0;
         as_cnt   <= 40'h0;
      end else if (ce && autosave_nv) begin
         if (!as_first && idle_s2) begin
            as_first <= 1'b1; // [R5]
            as_cnt   <= 40'(AUTOSAVE_CYCLES - 1);
         end else if (as_first) begin
            as_cnt <= (as_cnt == 40'h0) ? 40'(AUTOSAVE_CYCLES - 1) : as_cnt - 40'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   as_fail_sig_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && captive && (state inside {ST_CAPT, ST_SPANS}) && err_s2 && !cmd_go
      |=> tf.lba_low == FAIL_LBA_LOW && tf.lba_high == FAIL_LBA_HIGH && tf.err) // [R14]
      else $error("captive failure signature wrong");
   as_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && cmd_go && cmd_feat == SC_AUTOSAVE && cmd_count != AS_OFF && cmd_count != AS_ON
      |=> $stable(autosave_nv) && tf.err) // [R7]
      else $error("bad auto-save count changed state");
   as_on_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && cmd_go && cmd_feat == SC_AUTOSAVE && cmd_count == AS_ON |=> autosave_nv) // [R6]
      else $error("auto-save not enabled");
   rv_seq_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && cmd_go && cmd_feat == SC_READ_VALUES
      |=> tf.busy ##1 (!ce or (tf.drq && !tf.busy && intrq))) // [R3]
      else $error("read values sequence wrong");
   off_busy_a: assert property (@(posedge aclk) disable iff (!aresetn)
      offline_run |-> !tf.busy && tf.drdy) // [R11]
      else $error("busy seen during off-line run");
   bad_code_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && cmd_go && cmd_feat == 8'h00 |=> tf.err && tf.error == ERR_ABORT) // [R23]
      else $error("reserved code not aborted");
   scan_start_a: assert property (@(posedge aclk) disable iff (!aresetn)
      state == ST_SCAN && $past(state) != ST_SCAN && $past(state) != ST_WAIT
      |-> scan.pending && scan.active && coll_status == COLL_SCANNING) // [R19]
      else $error("off-line scan flags wrong");
   scan_done_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && state == ST_SCAN && idle_s2 |=> scan == '0 && coll_status == COLL_DONE) // [R21]
      else $error("scan completion wrong");
   svc_time_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && cmd_cut |=> !offline_run && state == ST_IDLE) // [R12]
      else $error("host not served");
   svc_late_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && svc_cnt == 32'h1 |-> cmd_go) // [R12]
      else $error("service window ran out");

   cov_capt_c: cover property (@(posedge aclk) state == ST_CAPT && err_s2);
   cov_scan_c: cover property (@(posedge aclk) state == ST_SCAN);
   cov_xfer_c: cover property (@(posedge aclk) state == ST_XFER && xfer_cnt == 8'h1);

endmodule // dhs_unit

// >>> verif/dhs_drive_model.sv
`timescale 1ns/1ps
module dhs_drive_model (
   // clock and bench commands
   input  wire logic       aclk,
   input  wire logic       idle_cmd,
   input  wire logic       fail_cmd,
   // unit side
   input  wire logic       save_pulse,
   output logic            active_idle,
   output logic            test_error,
   output logic            power_resume,
   output logic [7:0]      n_saves
);
   // ----------------------------------------------------------------
   // drive-side pins
   // ----------------------------------------------------------------
   initial begin
      active_idle = 1'b0;
      test_error = 1'b0;
      power_resume = 1'b0;
      n_saves = 8'h00;
   end
   // active_idle and test_error follow bench commands, power_resume stays low; errors appear only when a test asks for them
   always @(posedge aclk) begin
      active_idle <= idle_cmd;
      test_error <= fail_cmd;
      if (save_pulse)
         n_saves <= n_saves + 8'h01;
   end
endmodule // dhs_drive_model

// >>> verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import dhs_pkg::*;
   // ----------------------------------------------------------------
   // stimulus and wiring
   // ----------------------------------------------------------------
   logic aclk = 0, aresetn = 0, ce = 1, idle_cmd = 0, fail_cmd = 0;
   logic s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0;
   logic [7:0] s_awaddr = 0, s_araddr = 0, n_saves, n0;
   logic [31:0] s_wdata = 0, rd_v, s_rdata;
   logic [3:0] s_wstrb = 4'hf;
   logic [1:0] s_bresp, s_rresp;
   logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
   logic save_pulse, intrq, autosave_nv, active_idle, test_error, power_resume;
   int n_fail = 0, num_checks = 0, cyc = 0, n_irq = 0, i0;
   always #12.5 aclk = ~aclk;
   always @(posedge aclk) if (intrq) n_irq <= n_irq + 1; // completion interrupts seen
   dhs_unit #(.AUTOSAVE_CYCLES(64), .SERVICE_CYCLES(64)) u_dhs_unit (.aclk, .aresetn, .ce,
      .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp,
      .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid,
      .s_rready, .active_idle, .test_error, .power_resume, .save_pulse, .intrq, .autosave_nv);
   dhs_drive_model u_dhs_drive_model (.aclk, .idle_cmd, .fail_cmd, .save_pulse, .active_idle,
      .test_error, .power_resume, .n_saves);
   // ----------------------------------------------------------------
   // bus tasks and checks
   // ----------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_awaddr <= a; s_wdata <= d; s_awvalid <= 1; s_wvalid <= 1; s_bready <= 1;
      do @(posedge aclk) begin
         if (s_awready) s_awvalid <= 0;
         if (s_wready) s_wvalid <= 0;
      end while (!s_bvalid);
      s_bready <= 0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge aclk);
      s_araddr <= a; s_arvalid <= 1; s_rready <= 1;
      do @(posedge aclk) if (s_arready) s_arvalid <= 0; while (!s_rvalid);
      d = s_rdata;
      s_rready <= 0;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   // poll status until the masked bits match; bounded so a hang is reported
   task automatic poll(input logic [31:0] m, input logic [31:0] v);
      for (int k = 0; k < 300; k++) begin
         rd(OFF_STATUS, rd_v);
         if ((rd_v & m) === v) return;
      end
      check(rd_v & m, v);
   endtask
   task automatic cmd(input logic [7:0] lba, input logic [7:0] sc, input logic [7:0] ft);
      wr(OFF_CMD, {8'h00, lba, sc, ft}); // feature byte goes with the command
      poll(32'h1, 32'h0);
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         n_fail++;
         give_verdict;
      end
   end
   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1;
      rd(OFF_STATUS, rd_v); check(rd_v[1:0], 2'b10);
      i0 = n_irq;
      cmd(8'h00, AS_ON, SC_AUTOSAVE); check(autosave_nv, 1'b1);
      check(n_irq - i0, 32'd1);
      idle_cmd <= 1;
      repeat (150) @(posedge aclk);
      check(n_saves >= 8'h02, 1'b1);
      cmd(8'h00, 8'h55, SC_AUTOSAVE); check(autosave_nv, 1'b1);
      rd(OFF_STATUS, rd_v); check(rd_v[7:4], ERR_ABORT[3:0]);
      cmd(8'h00, AS_OFF, SC_AUTOSAVE); check(autosave_nv, 1'b0);
      n0 = n_saves;
      cmd(8'h00, 8'h00, SC_SAVE); check(n_saves, n0 + 8'h01);
      wr(OFF_CMD, {24'h0, SC_READ_VALUES}); poll(32'h5, 32'h4);
      repeat (128) rd(OFF_DATA, rd_v);
      rd(OFF_STATUS, rd_v); check(rd_v[2], 1'b0);
      cmd(8'h00, 8'h00, 8'h00); check(rd_v[7:3], {ERR_ABORT[3:0], 1'b1});
      fail_cmd <= 1;
      cmd(RT_CAP_SHORT, 8'h00, SC_IMMEDIATE); check(rd_v[3], 1'b1);
      rd(OFF_RESULT, rd_v); check(rd_v[31:16], {FAIL_LBA_HIGH, FAIL_LBA_LOW});
      check(rd_v[15:8], TEST_FAILED);
      fail_cmd <= 0;
      rd(8'h40, rd_v); check(rd_v, 32'h0);
      idle_cmd <= 0;
      wr(OFF_SPANDEF, 32'h1); // span log set before the test starts
      wr(OFF_CMD, {8'h00, RT_SELECTIVE, 16'h00d4});
      rd(OFF_STATUS, rd_v); check(rd_v[1:0], 2'b10);
      rd(OFF_SCAN, rd_v); check(rd_v[4:0], {2'b11, SPAN_OFFLINE});
      rd(OFF_RESULT, rd_v); check(rd_v[15:0], {TEST_OK, COLL_SCANNING});
      cmd(RT_ABORT_SEL, 8'h00, SC_IMMEDIATE);
      rd(OFF_SCAN, rd_v); check(rd_v[4:0], 5'h00);
      wr(OFF_CMD, {8'h00, RT_SELECTIVE, 16'h00d4}); idle_cmd <= 1;
      repeat (12) @(posedge aclk);
      rd(OFF_RESULT, rd_v); check(rd_v[7:0], COLL_DONE);
      wr(OFF_CMD, {8'h00, RT_SHORT, 16'h00d4});
      rd(OFF_STATUS, rd_v); check(rd_v[1:0], 2'b10);
      give_verdict;
   end
endmodule // tb_top
